// [core/csf_status_reg.sv]
`timescale 1ns/1ps
// Behaviour
// - status register may be any instruction's destination
// - flag-updating write blocks writes to zero, half carry, carry
// - watchdog expiry and sleep entered read-only, read 1 at reset
// - clear op zeroes bank bits, sets zero, keeps other bits
// - subtraction carry and half carry are inverted borrows
// - bit 7 selects indirect bank pair 0-1 or 2-3
// - bits 6:5 select the direct addressing bank
// - 128-byte banks; bank bits plus offset form data address
// - reset clears bank bits; arithmetic flags undefined (the code resets them to 0)
// - expiry flag set by power-up, watchdog clear, sleep; cleared on timeout
// - sleep flag set by power-up, watchdog clear; cleared by sleep
// - zero flag high when affecting result is zero
module csf_status_reg (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // register write from execution
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       clr_op,
  // alu operation
  input  wire logic       alu_en,
  input  wire logic [7:0] alu_a,
  input  wire logic [7:0] alu_b,
  input  wire logic       alu_sub,
  input  wire logic       alu_upd_z,
  input  wire logic       alu_upd_hc,
  // flag update from the alu result
  // watchdog and sleep events
  input  wire logic       wdt_clear_op,
  input  wire logic       sleep_op,
  input  wire logic       wdt_timeout,
  // outputs
  output logic [7:0]      status_rd,
  output logic [7:0]      alu_result,
  output logic [8:0]      direct_addr,
  output logic [8:0]      indirect_addr,
  // address offsets in
  input  wire logic [6:0] direct_ofs,
  input  wire logic [7:0] indirect_ofs
);
  // register state
  logic [2:0] bank_reg;
  logic [2:0] bank_next;
  logic       wdx_reg;
  logic       wdx_next;
  logic       slp_reg;
  logic       slp_next;
  logic       zero_reg;
  logic       zero_next;
  logic       hc_reg;
  logic       hc_next;
  logic       cy_reg;
  logic       cy_next;

  // decoded write intent
  logic [7:0] wr_eff;
  logic       upd_any;
  logic       dest_wr;
  logic       plain_wr;
  logic       z_from_alu;
  logic       c_from_alu;

  csf_flag_if fl ();

  csf_alu_flags u_alu (
    .op_a (alu_a),
    .op_b (alu_b),
    .sub  (alu_sub),
    .fl   (fl.alu)
  );

  assign alu_result = fl.result;

  // a flag-updating op is any alu op this cycle, even one that updates no flag
  assign upd_any = alu_en;
  // clear op writes zero as its result
  assign wr_eff = clr_op ? 8'h00 : wr_data;
  assign dest_wr = wr_en || clr_op;
  // plain write: no flag logic this cycle
  assign plain_wr = wr_en && !upd_any && !clr_op;
  // alu flags win over a plain write; clear op still wins for zero
  assign z_from_alu = upd_any && alu_upd_z;
  assign c_from_alu = upd_any && alu_upd_hc;

  always_comb begin
    bank_next = bank_reg;
    if (dest_wr) begin
      bank_next = wr_eff[csf_pkg::BIT_IND:csf_pkg::BIT_DLO];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bank_reg <= csf_pkg::BANK_RST;
    end else begin
      bank_reg <= bank_next;
    end
  end

  // expiry flag; timeout wins, it is the hardware event
  always_comb begin
    wdx_next = wdx_reg;
    if (wdt_timeout) begin
      wdx_next = 1'b0;
    end else if (wdt_clear_op || sleep_op) begin
      wdx_next = 1'b1;
    end
  end

  // no write path reaches this flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdx_reg <= csf_pkg::WDX_RST;
    end else begin
      wdx_reg <= wdx_next;
    end
  end

  // sleep flag; sleep beats watchdog clear
  always_comb begin
    slp_next = slp_reg;
    if (sleep_op) begin
      slp_next = 1'b0;
    end else if (wdt_clear_op) begin
      slp_next = 1'b1;
    end
  end

  // no write path reaches this flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slp_reg <= csf_pkg::SLP_RST;
    end else begin
      slp_reg <= slp_next;
    end
  end

  always_comb begin
    zero_next = zero_reg;
    if (clr_op) begin
      zero_next = 1'b1;
    end else if (z_from_alu) begin
      zero_next = fl.zero;
    end else if (plain_wr) begin
      zero_next = wr_data[csf_pkg::BIT_ZERO];
    end
  end

  // flags nominally undefined; zero keeps runs free of x
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      zero_reg <= csf_pkg::ARITH_RST[2];
    end else begin
      zero_reg <= zero_next;
    end
  end

  // half carry is inverted digit borrow on subtract
  always_comb begin
    hc_next = hc_reg;
    if (c_from_alu) begin
      hc_next = fl.hc;
    end else if (plain_wr) begin
      hc_next = wr_data[csf_pkg::BIT_HC];
    end
  end

  // software must not rely on this value before a first update
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hc_reg <= csf_pkg::ARITH_RST[1];
    end else begin
      hc_reg <= hc_next;
    end
  end

  // carry is inverted borrow on subtract
  always_comb begin
    cy_next = cy_reg;
    if (c_from_alu) begin
      cy_next = fl.cy;
    end else if (plain_wr) begin
      cy_next = wr_data[csf_pkg::BIT_CY];
    end
  end

  // software must not rely on this value before a first update
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cy_reg <= csf_pkg::ARITH_RST[0];
    end else begin
      cy_reg <= cy_next;
    end
  end

  // read-only flags visible on read
  // status is read straight from the flops, never from next values
  assign status_rd = {bank_reg, wdx_reg, slp_reg, zero_reg, hc_reg, cy_reg};

  // offsets come from the instruction or the pointer register

  assign direct_addr = {bank_reg[1:0], direct_ofs};
  assign indirect_addr = {bank_reg[2], indirect_ofs};
endmodule

// [core/csf_pkg.sv]
package csf_pkg;
  // bit positions of the status register
  localparam int BIT_IND  = 7;
  localparam int BIT_DHI  = 6;
  localparam int BIT_DLO  = 5;
  localparam int BIT_WDX  = 4;
  localparam int BIT_SLP  = 3;
  localparam int BIT_ZERO = 2;
  localparam int BIT_HC   = 1;
  localparam int BIT_CY   = 0;

  // power-on values
  localparam logic [2:0] BANK_RST  = 3'h0;
  localparam logic       WDX_RST   = 1'h1;
  localparam logic       SLP_RST   = 1'h1;
  localparam logic [2:0] ARITH_RST = 3'h0;

  // data address layout: 128-byte banks
  localparam int BANK_OFS_W = 7;
  localparam int DADDR_W    = 9;
  localparam int IND_OFS_W  = 8;

  // writable bits for a plain write
  localparam logic [7:0] WR_MASK = 8'hE7;
  localparam logic [7:0] FLAG_MASK = 8'h07;
endpackage

// [core/csf_flag_if.sv]
`timescale 1ns/1ps
interface csf_flag_if;
  logic       zero;
  logic       hc;
  logic       cy;
  logic [7:0] result;
  modport alu (output zero, output hc, output cy, output result);
  modport reg_side (input zero, input hc, input cy, input result);
endinterface

// [core/csf_alu_flags.sv]
`timescale 1ns/1ps
module csf_alu_flags (
  // operands
  input  wire logic [7:0] op_a,
  input  wire logic [7:0] op_b,
  input  wire logic       sub,
  // flags out
  csf_flag_if.alu         fl
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] b_eff;

  // subtract as add of two's complement; carry then is inverted borrow
  // inverted borrow
  always_comb begin
    b_eff = sub ? ~op_b : op_b;
    sum   = {1'b0, op_a} + {1'b0, b_eff} + {8'h00, sub};
    nib   = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, sub};
  end

  assign fl.result = sum[7:0];
  assign fl.cy     = sum[8];
  assign fl.hc     = nib[4];
  assign fl.zero   = (sum[7:0] == 8'h00);
endmodule

// [tb/csf_exec_model.sv]
`timescale 1ns/1ps
module csf_exec_model (
  // command from the bench
  input  wire logic        clk,
  input  wire logic [32:0] cmd,
  // toward the status register
  output logic      [8:0]  ctl,
  output logic      [23:0] opnd
);
  initial {ctl, opnd} = 33'h0;
  // whole ops only, launched just after the edge
  always @(posedge clk) {ctl, opnd} <= #1 cmd;
endmodule

// [tb/csf_chk_assertions.sv]
`timescale 1ns/1ps
module csf_chk (
  // clock and requests
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       wr_en,
  input wire logic [7:0] wr_data,
  input wire logic       clr_op,
  input wire logic       alu_en,
  input wire logic       alu_upd_z,
  input wire logic [7:0] alu_result,
  input wire logic       wdt_clear_op,
  input wire logic       sleep_op,
  input wire logic       wdt_timeout,
  // results
  input wire logic [7:0] status_rd,
  input wire logic [8:0] direct_addr,
  input wire logic [6:0] direct_ofs,
  input wire logic [8:0] indirect_addr,
  input wire logic [7:0] indirect_ofs
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_ro_bits_hold: assert property (
    !(wdt_clear_op | sleep_op | wdt_timeout) |=> $stable(status_rd[4:3]))
    else $error("read-only bits moved");
  chk_timeout_clears: assert property (
    wdt_timeout |=> !status_rd[4]) else $error("expiry flag not cleared");
  chk_sleep_clears: assert property (
    sleep_op |=> !status_rd[3]) else $error("sleep flag not cleared");
  chk_wdt_clear_sets: assert property (
    wdt_clear_op && !sleep_op && !wdt_timeout |=> status_rd[4:3] == 2'h3)
    else $error("watchdog clear missed");
  chk_clear_op: assert property (
    clr_op && !wr_en && !alu_en |=> status_rd[7:5] == 3'h0 && status_rd[2])
    else $error("clear op wrong");
  chk_plain_write: assert property (
    wr_en && !alu_en && !clr_op |=>
    (status_rd & 8'hE7) == ($past(wr_data) & 8'hE7))
    else $error("plain write wrong");
  chk_bank_hold: assert property (
    !wr_en && !clr_op |=> $stable(status_rd[7:5]))
    else $error("bank bits moved");
  chk_direct_addr: assert property (
    direct_addr == {status_rd[6:5], direct_ofs})
    else $error("direct address wrong");
  chk_indirect_addr: assert property (
    indirect_addr == {status_rd[7], indirect_ofs})
    else $error("indirect address wrong");
  chk_zero_update: assert property (
    alu_en && alu_upd_z && !clr_op |=>
    status_rd[2] == ($past(alu_result) == 8'h00))
    else $error("zero flag wrong");
  chk_write_blocked: assert property (
    alu_en && wr_en && !clr_op && !alu_upd_z |=>
    status_rd[2] == $past(status_rd[2]))
    else $error("zero flag not protected");
endmodule
bind csf_status_reg csf_chk u_chk (.*);

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [32:0] cmd = 33'h0;
  logic [23:0] opnd;
  logic [7:0]  status_rd;
  logic [7:0]  alu_result;
  logic [8:0]  ctl, direct_addr, indirect_addr;
  int          num_errors = 0, n_compared = 0, cyc = 0;
  // controls, write data, a, b, expected status
  localparam logic [40:0] ROWS [10] = '{
    {9'h100, 24'hFF0000, 8'hFF}, {9'h100, 24'h000000, 8'h18},
    {9'h178, 24'hE00503, 8'hFB}, {9'h080, 24'h000000, 8'h1F},
    {9'h078, 24'h000305, 8'h18}, {9'h078, 24'h000505, 8'h1F},
    {9'h001, 24'h000000, 8'h0F}, {9'h002, 24'h000000, 8'h17},
    {9'h004, 24'h000000, 8'h1F}, {9'h100, 24'hE00000, 8'hF8}};
  csf_exec_model u_exec (.clk(clk), .cmd(cmd), .ctl(ctl), .opnd(opnd));
  csf_status_reg DUT (.clk(clk), .rstn(rstn), .wr_en(ctl[8]),
    .clr_op(ctl[7]), .alu_en(ctl[6]), .alu_sub(ctl[5]),
    .alu_upd_z(ctl[4]), .alu_upd_hc(ctl[3]), .wdt_clear_op(ctl[2]),
    .sleep_op(ctl[1]), .wdt_timeout(ctl[0]), .wr_data(opnd[23:16]),
    .alu_a(opnd[15:8]), .alu_b(opnd[7:0]), .status_rd(status_rd),
    .alu_result(alu_result), .direct_addr(direct_addr),
    .indirect_addr(indirect_addr), .direct_ofs(7'h2A),
    .indirect_ofs(8'h5C));
  always #5 clk = ~clk;
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // about 25 cycles needed; a hang stops well short of forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 100) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    foreach (ROWS[i]) begin
      cmd = ROWS[i][40:8];
      @(posedge clk) #1 cmd = 33'h0;
      @(posedge clk) #2;
      cmp(9'(status_rd), 9'(ROWS[i][7:0])); // rows
    end
    // write with a flag op: carries and bank bits land, zero is protected
    cmd = {9'h168, 24'hE00905};
    @(posedge clk) #2 cmp(9'(alu_result), 9'h004);
    cmd = 33'h0;
    @(posedge clk) #2 cmp(9'(status_rd), 9'h0FB);
    cmp(direct_addr, 9'h1AA); // direct bank 3
    cmp(indirect_addr, 9'h15C); // indirect banks 2-3
    #1 rstn = 1'b0;
    #1 cmp(9'(status_rd), 9'h018); // mid-run reset
    cmp(direct_addr, 9'h02A); // direct bank 0
    cmp(indirect_addr, 9'h05C); // indirect banks 0-1
    conclude();
  end
endmodule
